// File: bench/smd_decode_monitor.sv
// checker: select, reset and flash status relations at the decoder ports
`timescale 1ns/100ps
module smd_decode_monitor #(
    parameter int MAIN_N = 8,
    parameter logic RST_OUT_HIGH = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic program_fetch_strobe_n_i,
    input wire logic [MAIN_N-1:0] main_flash_sector_select_o,
    input wire logic [smd_pkg::SEC_SECTORS-1:0] secondary_flash_sector_select_o,
    input wire logic sram_select_o,
    input wire logic window_select_o,
    input wire logic [smd_pkg::PAGE_W-1:0] page_o,
    input wire logic rst_out_o,
    input wire logic main_standby_o,
    input wire logic main_busy_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire idle = rd_n_i & wr_n_i & program_fetch_strobe_n_i;
    wire [MAIN_N+5:0] sels = {main_flash_sector_select_o, secondary_flash_sector_select_o,
        sram_select_o, window_select_o};
    property p_one_sel; $onehot0(sels); endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects at once");
    property p_drop; idle |=> sels == '0; endproperty
    a_drop: assert property (p_drop) else $error("select without strobe");
    property p_win; window_select_o |-> $past(program_fetch_strobe_n_i) && !$past(idle);
    endproperty
    a_win: assert property (p_win) else $error("window select not data cycle");
    property p_sram; sram_select_o |-> $past(program_fetch_strobe_n_i) && !$past(idle);
    endproperty
    a_sram: assert property (p_sram) else $error("sram select not data cycle");
    property p_page; $rose(reset_n_i) |-> page_o == 8'h00; endproperty
    a_page: assert property (p_page) else $error("page not clear after reset");
    property p_rst; $rose(reset_n_i) |-> rst_out_o == RST_OUT_HIGH ##1 rst_out_o != RST_OUT_HIGH;
    endproperty
    a_rst: assert property (p_rst) else $error("forwarded reset wrong");
    property p_busy; $rose(main_busy_o) |-> !$past(wr_n_i, 2); endproperty
    a_busy: assert property (p_busy) else $error("busy without write");
    property p_sby; (idle && !main_busy_o) [*3] |-> main_standby_o; endproperty
    a_sby: assert property (p_sby) else $error("no standby when idle");
endmodule // smd_decode_monitor

bind smd_decode smd_decode_monitor #(.MAIN_N(MAIN_N), .RST_OUT_HIGH(RST_OUT_HIGH)) u_mon (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
    .program_fetch_strobe_n_i(program_fetch_strobe_n_i),
    .main_flash_sector_select_o(main_flash_sector_select_o),
    .secondary_flash_sector_select_o(secondary_flash_sector_select_o),
    .sram_select_o(sram_select_o), .window_select_o(window_select_o), .page_o(page_o),
    .rst_out_o(rst_out_o), .main_standby_o(main_standby_o), .main_busy_o(main_busy_o));

// File: bench/smd_host_model.sv
// host core model: multiplexed address/data bus cycles toward the decoder
`timescale 1ns/100ps
module smd_host_model (
    input wire logic core_clk_i,
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic pf_n_o,
    output logic [15:0] ad_o,
    output logic drv_o,
    output logic ans_o
);
    initial begin
        ale_o = 1'b0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        pf_n_o = 1'b1;
        ad_o = 16'h0000;
        drv_o = 1'b0;
        ans_o = 1'b0;
    end
    // kind 0 fetch, 1 read, 2 write; address phase then strobe phase
    task automatic cyc(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        ale_o <= 1'b1;
        ad_o <= a;
        drv_o <= 1'b1;
        @(posedge core_clk_i);
        ale_o <= 1'b0;
        pf_n_o <= k != 2'h0;
        rd_n_o <= k != 2'h1;
        wr_n_o <= k != 2'h2;
        ad_o <= {8'h00, d};
        drv_o <= k == 2'h2;
        @(posedge core_clk_i);
        ans_o <= 1'b1;
        @(posedge core_clk_i);
        ans_o <= 1'b0;
        pf_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        @(posedge core_clk_i);
    endtask
endmodule // smd_host_model

// File: bench/tb_top.sv
// testbench: host model runs bus cycles; selects, read data and status checked
`timescale 1ns/100ps
module tb_top;
    localparam logic [191:0] MB = {24'h01c000, 24'h018000, 24'h014000, 24'h010000,
        24'h00c000, 24'h008000, 24'h004000, 24'h000000};
    localparam logic [95:0] SB = {24'h028000, 24'h026000, 24'h024000, 24'h022000};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ale, rd_n, wr_n, pf_n, drv, ans, sr, ws, ro, mst, sst, mb, sb;
    logic [15:0] had, ad_w, uo, oe, mc;
    logic [7:0] ms, me, pg;
    logic [3:0] ss, se;
    logic [13:0] qs[$];
    logic [15:0] qr[$];
    int miscompares = 0;
    int checks_done = 0;
    wire [15:0] st = {3'b000, pg, ro, mst, sst, mb, sb};
    wire [15:0] fs = {me, se, 2'b00, mb, sb};
    // released host lines show the inverse of their last value
    assign ad_w = (oe & uo) | (~oe & (drv ? had : ~had));
    initial begin
        forever #4 clk = ~clk;
    end
    smd_host_model host (.core_clk_i(clk), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .pf_n_o(pf_n), .ad_o(had), .drv_o(drv), .ans_o(ans));
    smd_decode #(.MAIN_BASE(MB), .MAIN_IN_DATA(8'hf0), .SEC_BASE(SB), .SEC_IN_DATA(4'hc)) uut (
        .core_clk_i(clk), .reset_n_i(rst_n), .ad_i(ad_w), .ad_o(uo), .ad_oe_o(oe),
        .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .program_fetch_strobe_n_i(pf_n),
        .main_flash_sector_select_o(ms), .secondary_flash_sector_select_o(ss),
        .sram_select_o(sr), .window_select_o(ws), .page_o(pg), .mcell_o(mc), .rst_out_o(ro),
        .main_standby_o(mst), .sec_standby_o(sst), .main_busy_o(mb), .sec_busy_o(sb),
        .main_erase_o(me), .sec_erase_o(se));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic op(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d,
            input logic [13:0] es, input logic [15:0] er);
        qs.push_back(es);
        qr.push_back(er);
        host.cyc(k, a, d);
    endtask
    // fetch or read as asked, then the other kind at the same address selects nothing
    task automatic pair(input logic f, input logic [15:0] a, input logic [13:0] es);
        op(f ? 2'h0 : 2'h1, a, 8'h00, es, 16'h0000);
        op(f ? 2'h1 : 2'h0, a, 8'h00, 14'h0000, 16'h0000);
    endtask
    task automatic wait_idle();
        for (int n = 0; n < 1000 && (mb || sb); n++) @(posedge clk);
        chk({14'h0000, mb, sb}, 16'h0000);
    endtask
    always @(posedge clk) begin
        if (ans) begin
            chk({2'b00, ms, ss, sr, ws}, {2'b00, qs.pop_front()});
            chk({oe[7:0], uo[7:0] & oe[7:0]}, qr.pop_front());
        end
    end
    initial begin
        #160000;
        miscompares++;
        end_of_test();
    end
    initial begin
        logic [15:0] a, d;
        void'($urandom(32'hd595));
        repeat (4) @(posedge clk);
        chk(st, 16'h000c);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk(st, 16'h001c);
        for (int i = 0; i < 8; i++) begin
            if (i == 4) op(2'h2, 16'hffe0, 8'h01, 14'h0001, 16'h0000);
            a = {2'(i), 3'b110, 11'($urandom)};
            pair(i < 4, a, 14'h0040 << i);
        end
        op(2'h1, 16'hffe0, 8'h00, 14'h0001, 16'hff01);
        $display("test main flash done");
        op(2'h2, 16'hffe0, 8'h02, 14'h0001, 16'h0000);
        for (int j = 0; j < 4; j++) begin
            a = {3'(j + 1), 13'($urandom)};
            pair(j < 2, a, 14'h0004 << j);
        end
        $display("test secondary flash done");
        op(2'h2, 16'hffe0, 8'h01, 14'h0001, 16'h0000);
        op(2'h2, 16'hffc0, 8'h10, 14'h0001, 16'h0000);
        op(2'h2, 16'h0123, 8'h30, 14'h0400, 16'h0000);
        repeat (4) @(posedge clk);
        chk(fs, 16'h0000);
        op(2'h2, 16'h4123, 8'h30, 14'h0800, 16'h0000);
        repeat (4) @(posedge clk);
        chk(fs, 16'h2002);
        op(2'h2, 16'hffe0, 8'h02, 14'h0001, 16'h0000);
        op(2'h0, 16'h2abc, 8'h00, 14'h0004, 16'h0000);
        op(2'h2, 16'h8abc, 8'ha0, 14'h0020, 16'h0000);
        repeat (4) @(posedge clk);
        chk(fs, 16'h2003);
        wait_idle();
        op(2'h2, 16'hffe0, 8'h01, 14'h0001, 16'h0000);
        op(2'h2, 16'h8000, 8'h10, 14'h1000, 16'h0000);
        repeat (4) @(posedge clk);
        chk(fs, 16'hef02);
        wait_idle();
        $display("test erase and protect done");
        op(2'h2, 16'hffe0, 8'h00, 14'h0001, 16'h0000);
        op(2'h1, 16'h0abc, 8'h00, 14'h0002, 16'h0000);
        op(2'h2, 16'h0abc, 8'h5a, 14'h0002, 16'h0000);
        op(2'h0, 16'h0abc, 8'h00, 14'h0040, 16'h0000);
        op(2'h0, 16'hff10, 8'h00, 14'h0200, 16'h0000);
        d = 16'($urandom);
        op(2'h2, 16'hff20, d[7:0], 14'h0001, 16'h0000);
        op(2'h2, 16'hff21, d[15:8], 14'h0001, 16'h0000);
        op(2'h1, 16'hff20, 8'h00, 14'h0001, {8'hff, d[7:0]});
        op(2'h1, 16'hff21, 8'h00, 14'h0001, {8'hff, d[15:8]});
        chk(mc, d);
        op(2'h2, 16'hffc2, 8'h77, 14'h0001, 16'h0000);
        op(2'h1, 16'hffc2, 8'h00, 14'h0001, 16'hff07);
        op(2'h1, 16'hffc4, 8'h00, 14'h0001, 16'hff0c);
        $display("test sram and window done");
        end_of_test();
    end
endmodule // tb_top

// File: hdl/smd_decode.sv
// top: multiplexed-bus memory select decoder with flash and window control
//
// Behaviour
// - 16-bit multiplexed address/data bus with legacy strobes; prefetch stays on host.
// - reset from host active-low reset; forwardable to logic pin, either polarity.
// - host bus reads and writes the logic macrocells a byte at a time, low byte and high byte.
// - two flash arrays independent; fetch from one while other erases/programs.
// - each array accepts single-sector or whole-array erase.
// - per-sector write protect makes host writes to that sector ignored.
// - each flash array enters standby when neither accessed nor busy erasing/programming.
// - main flash equal sectors, one select each, only in its configured range.
// - main sectors map to program space or data space with matching strobes.
// - secondary flash four equal sectors, one select each, in own range.
// - secondary sectors map to program or data space with matching strobes.
// - SRAM one select, data space only, read/write strobes.
// - 256-byte control window selected at configurable base.
// - control window always data space, never program fetch.
// - window registers addressed by offset; only some locations implemented.
// - 8-bit page register clears to zero at reset, feeds decoder.
`timescale 1ns/100ps
module smd_decode #(
    parameter int MAIN_N = smd_pkg::MAIN_SECTORS,
    parameter int MAIN_SZ_W = 14,
    parameter logic [MAIN_N*24-1:0] MAIN_BASE = '0,
    parameter logic [MAIN_N-1:0] MAIN_IN_DATA = '0,
    parameter logic [smd_pkg::SEC_SECTORS*24-1:0] SEC_BASE = '0,
    parameter logic [smd_pkg::SEC_SECTORS-1:0] SEC_IN_DATA = '0,
    parameter int SEC_SZ_W = 13,
    parameter logic [23:0] SRAM_BASE = 24'h000000,
    parameter int SRAM_SZ_W = 12,
    parameter logic [15:0] WIN_BASE = 16'hff00,
    parameter logic RST_OUT_HIGH = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] ad_i,
    output logic [15:0] ad_o,
    output logic [15:0] ad_oe_o,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic program_fetch_strobe_n_i,
    output logic [MAIN_N-1:0] main_flash_sector_select_o,
    output logic [smd_pkg::SEC_SECTORS-1:0] secondary_flash_sector_select_o,
    output logic sram_select_o,
    output logic window_select_o,
    output logic [smd_pkg::PAGE_W-1:0] page_o,
    output logic [15:0] mcell_o,
    output logic rst_out_o,
    output logic main_standby_o,
    output logic sec_standby_o,
    output logic main_busy_o,
    output logic sec_busy_o,
    output logic [MAIN_N-1:0] main_erase_o,
    output logic [smd_pkg::SEC_SECTORS-1:0] sec_erase_o
);
    // lowest set bit only, so overlapping ranges still give one select
    function automatic logic [31:0] lowest_one(input logic [31:0] v);
        return v & ~(v - 32'h1);
    endfunction

    function automatic logic in_range(input logic [23:0] a, input logic [23:0] base,
                                      input int sz_w);
        logic [23:0] msk;
        msk = ~((24'h1 << sz_w) - 24'h1);
        return (a & msk) == (base & msk);
    endfunction

    logic [15:0] addr_q;
    logic [smd_pkg::PAGE_W-1:0] page_q;
    logic [15:0] mcell_q;
    logic [MAIN_N-1:0] wp_main_q;
    logic [smd_pkg::SEC_SECTORS-1:0] wp_sec_q;
    logic [MAIN_N-1:0] fs_q;
    logic [smd_pkg::SEC_SECTORS-1:0] cs_q;
    logic rs_q, win_q, rst_q;
    logic [7:0] rdata_q;
    logic drive_q;
    logic wr_n_q;
    logic main_busy, sec_busy, main_sb, sec_sb, prog_m, prog_s;
    logic [MAIN_N-1:0] main_er;
    logic [smd_pkg::SEC_SECTORS-1:0] sec_er;

    // address latched on ALE; page extends it
    wire [23:0] full_addr = {page_q, addr_q};
    wire fetch = !program_fetch_strobe_n_i;
    wire data_cyc = !rd_n_i || !wr_n_i;
    wire wr_edge = !wr_n_i && wr_n_q;
    wire [7:0] wdata = ad_i[7:0];
    wire win_hit = data_cyc && addr_q[15:8] == WIN_BASE[15:8];
    wire [7:0] win_ofs = addr_q[7:0];

    logic [MAIN_N-1:0] fs_raw;
    logic [smd_pkg::SEC_SECTORS-1:0] cs_raw;
    for (genvar i = 0; i < MAIN_N; i++) begin : g_main
        assign fs_raw[i] = in_range(full_addr, MAIN_BASE[i*24 +: 24], MAIN_SZ_W) &&
                           (MAIN_IN_DATA[i] ? data_cyc : fetch);
    end
    for (genvar j = 0; j < smd_pkg::SEC_SECTORS; j++) begin : g_sec
        assign cs_raw[j] = in_range(full_addr, SEC_BASE[j*24 +: 24], SEC_SZ_W) &&
                           (SEC_IN_DATA[j] ? data_cyc : fetch);
    end
    wire rs_raw = data_cyc && in_range(full_addr, SRAM_BASE, SRAM_SZ_W);

    // priority: window, sram, secondary, main; only one passes
    wire [MAIN_N-1:0] fs_pick = MAIN_N'(lowest_one(32'(fs_raw)));
    wire [smd_pkg::SEC_SECTORS-1:0] cs_pick = smd_pkg::SEC_SECTORS'(lowest_one(32'(cs_raw)));
    wire rs_ok = rs_raw && !win_hit;
    wire cs_ok = !win_hit && !rs_raw;
    wire fs_ok = cs_ok && cs_raw == '0;
    wire [MAIN_N-1:0] fs_d = fs_ok ? fs_pick : '0;
    wire [smd_pkg::SEC_SECTORS-1:0] cs_d = cs_ok ? cs_pick : '0;

    wire win_wr = win_hit && wr_edge;
    wire win_rd = win_hit && !rd_n_i;
    logic [7:0] rdata_d;
    always_comb begin
        unique case (win_ofs)
            smd_pkg::OFS_PAGE: rdata_d = page_q;
            smd_pkg::OFS_MCELL_LO: rdata_d = mcell_q[7:0];
            smd_pkg::OFS_MCELL_HI: rdata_d = mcell_q[15:8];
            smd_pkg::OFS_WP_MAIN: rdata_d = 8'(wp_main_q);
            smd_pkg::OFS_WP_SEC: rdata_d = 8'(wp_sec_q);
            smd_pkg::OFS_FLASH_STAT: rdata_d = {4'h0, sec_sb, main_sb, sec_busy, main_busy};
            default: rdata_d = 8'h00;
        endcase
    end

    // address held from the latch cycle through the strobe phase
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            addr_q <= 16'h0000;
        end else if (ale_i) begin
            addr_q <= ad_i;
        end
    end

    // last write strobe level, so a long write acts only once
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            wr_n_q <= 1'b1;
        end else begin
            wr_n_q <= wr_n_i;
        end
    end

    // one write strobe per writable window byte; flash status and other offsets drop writes
    wire wr_page = win_wr && win_ofs == smd_pkg::OFS_PAGE;
    wire wr_mlo = win_wr && win_ofs == smd_pkg::OFS_MCELL_LO;
    wire wr_mhi = win_wr && win_ofs == smd_pkg::OFS_MCELL_HI;
    wire wr_wpm = win_wr && win_ofs == smd_pkg::OFS_WP_MAIN;
    wire wr_wps = win_wr && win_ofs == smd_pkg::OFS_WP_SEC;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            page_q <= smd_pkg::PAGE_RESET;
        end else if (wr_page) begin
            page_q <= wdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            mcell_q[7:0] <= 8'h00;
        end else if (wr_mlo) begin
            mcell_q[7:0] <= wdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            mcell_q[15:8] <= 8'h00;
        end else if (wr_mhi) begin
            mcell_q[15:8] <= wdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            wp_main_q <= '0;
        end else if (wr_wpm) begin
            wp_main_q <= wdata[MAIN_N-1:0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            wp_sec_q <= '0;
        end else if (wr_wps) begin
            wp_sec_q <= wdata[smd_pkg::SEC_SECTORS-1:0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            fs_q <= '0;
            cs_q <= '0;
            rs_q <= 1'b0;
            win_q <= 1'b0;
        end else begin
            fs_q <= fs_d;
            cs_q <= cs_d;
            rs_q <= rs_ok;
            win_q <= win_hit;
        end
    end

    // window read data and bus drive, both one cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= 8'h00;
            drive_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            drive_q <= win_rd;
        end
    end

    // forwarded reset, released one edge after the host reset
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            rst_q <= RST_OUT_HIGH;
        end else begin
            rst_q <= !RST_OUT_HIGH;
        end
    end

    // each array runs on its own sequencer
    smd_flash_ctl #(.SECTORS(MAIN_N)) u_main (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .sel_i(fs_d),
        .wr_i(wr_edge),
        .access_i(fs_d != '0),
        .data_i(wdata),
        .wp_i(wp_main_q),
        .busy_o(main_busy),
        .standby_o(main_sb),
        .erase_o(main_er),
        .prog_o(prog_m)
    );
    smd_flash_ctl #(.SECTORS(smd_pkg::SEC_SECTORS)) u_sec (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .sel_i(cs_d),
        .wr_i(wr_edge),
        .access_i(cs_d != '0),
        .data_i(wdata),
        .wp_i(wp_sec_q),
        .busy_o(sec_busy),
        .standby_o(sec_sb),
        .erase_o(sec_er),
        .prog_o(prog_s)
    );

    logic main_busy_q, sec_busy_q;
    logic [MAIN_N-1:0] main_er_q;
    logic [smd_pkg::SEC_SECTORS-1:0] sec_er_q;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            main_busy_q <= 1'b0;
            main_er_q <= '0;
        end else begin
            main_busy_q <= main_busy || prog_m;
            main_er_q <= main_er;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            sec_busy_q <= 1'b0;
            sec_er_q <= '0;
        end else begin
            sec_busy_q <= sec_busy || prog_s;
            sec_er_q <= sec_er;
        end
    end

    assign main_flash_sector_select_o = fs_q;
    assign secondary_flash_sector_select_o = cs_q;
    assign sram_select_o = rs_q;
    assign window_select_o = win_q;
    assign page_o = page_q;
    assign mcell_o = mcell_q;
    assign rst_out_o = rst_q;
    assign main_standby_o = main_sb;
    assign sec_standby_o = sec_sb;
    assign main_busy_o = main_busy_q;
    assign sec_busy_o = sec_busy_q;
    assign main_erase_o = main_er_q;
    assign sec_erase_o = sec_er_q;
    assign ad_o = {8'h00, rdata_q};
    assign ad_oe_o = {8'h00, {8{drive_q}}};
endmodule // smd_decode

// File: hdl/smd_flash_ctl.sv
// per-array flash sequencer: erase/program busy tracking and standby
`timescale 1ns/100ps
module smd_flash_ctl #(
    parameter int SECTORS = 8
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [SECTORS-1:0] sel_i,
    input wire logic wr_i,
    input wire logic access_i,
    input wire logic [7:0] data_i,
    input wire logic [SECTORS-1:0] wp_i,
    output logic busy_o,
    output logic standby_o,
    output logic [SECTORS-1:0] erase_o,
    output logic prog_o
);
    logic [smd_pkg::BUSY_W-1:0] cnt_q, cnt_d;
    logic [SECTORS-1:0] erase_q, erase_d;
    logic prog_q, prog_d;
    logic standby_q;
    wire hit = |(sel_i & ~wp_i);
    wire wr_ok = wr_i && hit && (cnt_q == '0);
    wire is_bulk = wr_ok && data_i == smd_pkg::CMD_BULK_ERASE;
    wire is_sect = wr_ok && data_i == smd_pkg::CMD_SECTOR_ERASE;
    wire is_prog = wr_ok && data_i == smd_pkg::CMD_PROGRAM;
    always_comb begin
        cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
        erase_d = (cnt_q > 1) ? erase_q : '0;
        prog_d = (cnt_q > 1) ? prog_q : 1'b0;
        if (is_bulk) begin
            cnt_d = smd_pkg::BUSY_W'(smd_pkg::ERASE_CYC);
            erase_d = ~wp_i;
        end else if (is_sect) begin
            cnt_d = smd_pkg::BUSY_W'(smd_pkg::ERASE_CYC);
            erase_d = sel_i & ~wp_i;
        end else if (is_prog) begin
            cnt_d = smd_pkg::BUSY_W'(smd_pkg::PROG_CYC);
            prog_d = 1'b1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cnt_q <= '0;
            erase_q <= '0;
            prog_q <= 1'b0;
            standby_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            erase_q <= erase_d;
            prog_q <= prog_d;
            standby_q <= !(access_i || cnt_d != '0);
        end
    end
    assign busy_o = cnt_q != '0;
    assign standby_o = standby_q;
    assign erase_o = erase_q;
    assign prog_o = prog_q;
endmodule // smd_flash_ctl

// File: hdl/smd_pkg.sv
// package: constants for the stacked memory select decoder
package smd_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 8;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;
    localparam int MAIN_SECTORS = 8;
    localparam int SEC_SECTORS = 4;
    localparam int WIN_BYTES = 256;
    localparam int WIN_REGS = 39;
    // window offsets used by this block
    localparam logic [7:0] OFS_PAGE = 8'he0;
    localparam logic [7:0] OFS_MCELL_LO = 8'h20;
    localparam logic [7:0] OFS_MCELL_HI = 8'h21;
    localparam logic [7:0] OFS_WP_MAIN = 8'hc0;
    localparam logic [7:0] OFS_WP_SEC = 8'hc2;
    localparam logic [7:0] OFS_FLASH_STAT = 8'hc4;
    // flash command bytes (data on write cycle into a flash select)
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    // time each flash operation stays busy, in cycles
    localparam int ERASE_NS = 4000;
    localparam int CLK_NS = 8;
    localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_NS = 400;
    localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_W = 12;
    typedef enum logic [1:0] {SMD_SPACE_NONE, SMD_SPACE_PROG, SMD_SPACE_DATA} smd_space_e;
endpackage
